// ### logic/epc_ctrl.sv
/*
 EEPROM program and erase sequencer with its control register.
 Assumes a core bus synchronous to mclk; array and option cell outside.
*/
//Behaviour
//- Byte select set: erase only addressed byte, row select ignored.
//- Byte select clear: row select 0 erases all, 1 erases 16-byte row.
//- Erase bit 0 means read or program, 1 means erase.
//- Latch clear: array reads normally, no programming; in EPC_LATCHED a write clearing it and setting voltage still programs.
//- Latch set: array writes captured, array reads blocked.
//- High voltage reaches the array only while voltage enable is 1.
//- On the ROM variant the same voltage bit serves both arrays.
//- ROM and EEPROM latch enables never both 1.
//- ROM latch selects read path at 0, programming path at 1.
//- Programming ignores row and byte select bits.
//- Programming only clears bits; erase first.
//- Writing zero to the control register ends every sequence.
//- Bulk erase leaves the option cell unchanged.
//- Option cell programmable and erasable in any mode unless guarded.
//- Security forces single-chip modes only.
//- Latch and voltage set in one write leaves both clear.
//- Voltage bit writable only while a latch is already set.
`timescale 1ns/100ps
`include "epc_params.svh"
module epc_ctrl #(
    parameter logic [15:0] ARRAY_BASE = 16'hb600,
    parameter logic [15:0] ARRAY_LAST = 16'hb7ff,
    parameter logic [15:0] OPTION_ADDR = 16'h103f,
    parameter int unsigned HOLD_CYCLES = `EPC_HOLD_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire epc_pkg::epc_bus_t bus,
    input wire logic rom_variant,
    input wire logic option_write_guard,
    input wire logic security_on,
    input wire logic want_expanded,
    output logic [7:0] rdata,
    output logic array_read_en,
    output logic rom_prog_path,
    output logic hv_on,
    output logic hold_done,
    output logic single_chip_only,
    output epc_pkg::epc_nvm_cmd_t nvm_cmd
);
    typedef struct packed {
        logic [7:0] ctrl;
        epc_pkg::epc_state_t st;
        logic [31:0] cnt;
        logic [15:0] addr;
        logic [7:0] data;
        logic opt;
        logic [7:0] rdata;
        logic rd_en;
        logic rom_path;
        logic hv;
        logic done;
        logic sc_only;
        epc_pkg::epc_nvm_cmd_t cmd;
    } epc_state_regs_t;

    epc_state_regs_t s_r;
    epc_state_regs_t s_nxt;
    logic [7:0] filt;
    logic reg_hit;
    logic arr_hit;
    logic opt_hit;
    logic cap;

    assign reg_hit = bus.en && bus.addr == `EPC_PROG_CTRL_ADDR;
    assign arr_hit = bus.en && bus.addr >= ARRAY_BASE && bus.addr <= ARRAY_LAST;
    assign opt_hit = bus.en && bus.addr == OPTION_ADDR;
    // Guarded option writes must not arm the sequence either
    assign cap = (arr_hit || (opt_hit && !option_write_guard)) && bus.we
        && s_r.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE] && !s_r.ctrl[`EPC_BIT_PGM];

    epc_wr_filter u_filt (
        .cur(s_r.ctrl),
        .wdata(bus.wdata),
        .rom_variant(rom_variant),
        .nxt(filt)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.cmd.hv_on = 1'b0;
        if (reg_hit && bus.we) begin
            s_nxt.ctrl = filt;
        end
        if (reg_hit && !bus.we) begin
            s_nxt.rdata = s_r.ctrl;
        end
        // Writes to array or option cell captured only while latched
        if (cap) begin
            s_nxt.addr = bus.addr;
            s_nxt.data = bus.wdata;
            s_nxt.opt = opt_hit;
        end
        case (s_r.st)
            epc_pkg::EPC_IDLE: begin
                if (s_nxt.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE]) begin
                    s_nxt.st = epc_pkg::EPC_ARMED;
                end
            end
            epc_pkg::EPC_ARMED: begin
                if (cap) begin
                    s_nxt.st = epc_pkg::EPC_LATCHED;
                end
                if (!s_nxt.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE]) begin
                    s_nxt.st = epc_pkg::EPC_IDLE;
                end
            end
            epc_pkg::EPC_LATCHED: begin
                if (s_nxt.ctrl[`EPC_BIT_PGM]) begin
                    s_nxt.st = epc_pkg::EPC_HV;
                    s_nxt.cnt = '0;
                end else if (!s_nxt.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE]) begin
                    s_nxt.st = epc_pkg::EPC_IDLE;
                end
            end
            epc_pkg::EPC_HV: begin
                if (s_r.cnt < HOLD_CYCLES) begin
                    s_nxt.cnt = s_r.cnt + 32'h00000001;
                end
                if (!s_nxt.ctrl[`EPC_BIT_PGM]) begin
                    s_nxt.st = s_nxt.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE] ? epc_pkg::EPC_LATCHED
                        : epc_pkg::EPC_IDLE;
                end
            end
            default: s_nxt.st = epc_pkg::EPC_IDLE;
        endcase
        if (reg_hit && bus.we && bus.wdata == 8'h00) begin
            s_nxt.st = epc_pkg::EPC_IDLE;
        end
        s_nxt.hv = s_nxt.ctrl[`EPC_BIT_PGM];
        s_nxt.rd_en = !s_nxt.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE];
        s_nxt.rom_path = s_nxt.ctrl[`EPC_BIT_ROM_LATCH_ENABLE];
        s_nxt.done = s_r.st == epc_pkg::EPC_HV && s_r.cnt >= HOLD_CYCLES;
        // Security or no expansion request confines to single-chip
        s_nxt.sc_only = security_on | !want_expanded | s_r.sc_only & security_on;
        s_nxt.cmd.hv_on = s_nxt.st == epc_pkg::EPC_HV && s_nxt.hv;
        s_nxt.cmd.erase = s_nxt.ctrl[`EPC_BIT_ERASE];
        // Program ignores row and byte select
        s_nxt.cmd.byte_sel = s_nxt.cmd.erase && s_nxt.ctrl[`EPC_BIT_BYTE];
        s_nxt.cmd.row = s_nxt.cmd.erase && !s_nxt.ctrl[`EPC_BIT_BYTE]
            && s_nxt.ctrl[`EPC_BIT_ROW];
        // Bulk never issued when the option cell was the target
        s_nxt.cmd.bulk = s_nxt.cmd.erase && !s_nxt.ctrl[`EPC_BIT_BYTE]
            && !s_nxt.ctrl[`EPC_BIT_ROW] && !s_nxt.opt;
        s_nxt.cmd.addr = s_nxt.cmd.row
            ? {s_nxt.addr[15:`EPC_ROW_ADDR_LSB], 4'h0} : s_nxt.addr;
        s_nxt.cmd.data = s_nxt.cmd.erase ? 8'hff : s_nxt.data;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_r <= '{ctrl: `EPC_CTRL_RESET, st: epc_pkg::EPC_IDLE, cnt: '0, addr: '0,
                     data: '0, opt: 1'b0, rdata: '0, rd_en: 1'b1, rom_path: 1'b0,
                     hv: 1'b0, done: 1'b0, sc_only: 1'b1, cmd: '0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign array_read_en = s_r.rd_en;
    assign rom_prog_path = s_r.rom_path;
    assign hv_on = s_r.hv;
    assign hold_done = s_r.done;
    assign single_chip_only = s_r.sc_only;
    assign nvm_cmd = s_r.cmd;

    chk_latch_excl: assert property (@(posedge mclk) disable iff (srst)
        !(s_r.ctrl[`EPC_BIT_ROM_LATCH_ENABLE] && s_r.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE]))
        else $error("both latch enables set");
    chk_dual_set: assert property (@(posedge mclk) disable iff (srst)
        ce && reg_hit && bus.we && !s_r.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE] && bus.wdata[1:0] == 2'b11
        |=> s_r.ctrl[1:0] == 2'b00)
        else $error("latch and voltage set together");
    chk_pgm_guard: assert property (@(posedge mclk) disable iff (srst)
        $rose(s_r.ctrl[`EPC_BIT_PGM]) |-> $past(s_r.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE] | s_r.ctrl[`EPC_BIT_ROM_LATCH_ENABLE]))
        else $error("voltage set without latch");
    chk_hv_follow: assert property (@(posedge mclk) disable iff (srst)
        ce && reg_hit && bus.we && s_r.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE]
        |=> hv_on == $past(bus.wdata[`EPC_BIT_PGM]))
        else $error("high voltage mismatch");
    chk_read_block: assert property (@(posedge mclk) disable iff (srst)
        s_r.ctrl[`EPC_BIT_EEPROM_LATCH_ENABLE] |-> !array_read_en)
        else $error("array readable while latched");
    chk_zero_write: assert property (@(posedge mclk) disable iff (srst)
        ce && reg_hit && bus.we && bus.wdata == 8'h00 |=> ##1 !hv_on && array_read_en)
        else $error("zero write did not end sequence");
    chk_byte_over: assert property (@(posedge mclk) disable iff (srst)
        nvm_cmd.byte_sel |-> !nvm_cmd.row && !nvm_cmd.bulk)
        else $error("byte erase widened");
    chk_prog_plain: assert property (@(posedge mclk) disable iff (srst)
        !nvm_cmd.erase |-> !nvm_cmd.row && !nvm_cmd.byte_sel && !nvm_cmd.bulk)
        else $error("program used erase selects");
endmodule : epc_ctrl

// ### logic/epc_params.svh
/*
 Constants for the programming control block: register address, bit
 positions, reset value and timing figures. Assumes a 16-bit address bus.
*/
`ifndef EPC_PARAMS_SVH
`define EPC_PARAMS_SVH
`define EPC_PROG_CTRL_ADDR 16'h103b
`define EPC_BIT_PGM 0
`define EPC_BIT_EEPROM_LATCH_ENABLE 1
`define EPC_BIT_ERASE 2
`define EPC_BIT_ROW 3
`define EPC_BIT_BYTE 4
`define EPC_BIT_ROM_LATCH_ENABLE 5
`define EPC_CTRL_RESET 8'h00
`define EPC_ROW_BYTES 16
`define EPC_ROW_ADDR_LSB 4
`define EPC_CLK_MHZ 25
`define EPC_HOLD_MS 10
`define EPC_HOLD_CYCLES (`EPC_HOLD_MS * 1000 * `EPC_CLK_MHZ)
`endif

// ### logic/epc_pkg.sv
/*
 Types for the programming control block. Assumes the params header.
*/
package epc_pkg;
    typedef enum logic [3:0] {
        EPC_IDLE = 4'b0001,
        EPC_ARMED = 4'b0010,
        EPC_LATCHED = 4'b0100,
        EPC_HV = 4'b1000
    } epc_state_t;

    typedef enum logic [2:0] {
        EPC_OP_PROG = 3'b001,
        EPC_OP_BULK = 3'b010,
        EPC_OP_ROW = 3'b100
    } epc_kind_t;

    typedef struct packed {
        logic en;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } epc_bus_t;

    typedef struct packed {
        logic hv_on;
        logic erase;
        logic bulk;
        logic row;
        logic byte_sel;
        logic [15:0] addr;
        logic [7:0] data;
    } epc_nvm_cmd_t;
endpackage : epc_pkg

// ### logic/epc_wr_filter.sv
/*
 Write filter for the control register: applies the latch and voltage
 enable interlocks. Pure combinational; assumes current value given.
*/
`timescale 1ns/100ps
`include "epc_params.svh"
module epc_wr_filter (
    input wire logic [7:0] cur,
    input wire logic [7:0] wdata,
    input wire logic rom_variant,
    output logic [7:0] nxt
);
    logic latch_now;
    always_comb begin
        nxt = wdata & 8'h3f;
        latch_now = cur[`EPC_BIT_EEPROM_LATCH_ENABLE] | cur[`EPC_BIT_ROM_LATCH_ENABLE];
        if (!rom_variant) begin
            nxt[`EPC_BIT_ROM_LATCH_ENABLE] = 1'b0;
        end
        // Voltage bit only writable with a latch already set
        if (!latch_now) begin
            nxt[`EPC_BIT_PGM] = 1'b0;
        end
        // Latch bits frozen while high voltage is applied, except by a zero write
        if (cur[`EPC_BIT_PGM] && wdata != 8'h00) begin
            nxt[`EPC_BIT_ROM_LATCH_ENABLE] = cur[`EPC_BIT_ROM_LATCH_ENABLE];
            nxt[`EPC_BIT_EEPROM_LATCH_ENABLE] = cur[`EPC_BIT_EEPROM_LATCH_ENABLE];
        end
        // Setting latch and voltage in one write sets neither
        if (!cur[`EPC_BIT_EEPROM_LATCH_ENABLE] && wdata[`EPC_BIT_EEPROM_LATCH_ENABLE] && wdata[`EPC_BIT_PGM]) begin
            nxt[`EPC_BIT_EEPROM_LATCH_ENABLE] = 1'b0;
            nxt[`EPC_BIT_PGM] = 1'b0;
        end
        if (nxt[`EPC_BIT_ROM_LATCH_ENABLE] && nxt[`EPC_BIT_EEPROM_LATCH_ENABLE]) begin
            nxt[`EPC_BIT_ROM_LATCH_ENABLE] = 1'b0;
        end
    end
endmodule : epc_wr_filter

// ### sim/epc_core_model.sv
/* Core-side bus model: issues register and array accesses.
   Assumes the block samples its bus on the rising edge of mclk. */
`timescale 1ns/100ps
`include "epc_params.svh"
module epc_core_model (
    input wire logic mclk,
    output epc_pkg::epc_bus_t bus
);
    initial bus = '0;
    // Request held across one sampling edge; released lines show inverted junk
    task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        bus = '{en: 1'b1, we: we, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        bus = '{en: 1'b0, we: ~we, addr: ~a, wdata: ~d};
    endtask : acc
    // Mode alone, then the array write, then voltage added
    task automatic seq(input logic [7:0] mode, input logic [15:0] a, input logic [7:0] d);
        acc(1'b1, `EPC_PROG_CTRL_ADDR, mode);
        acc(1'b1, a, d);
        acc(1'b1, `EPC_PROG_CTRL_ADDR, mode | 8'h01);
    endtask : seq
endmodule : epc_core_model

// ### sim/test_eeprom_program_erase_control.sv
/* Bench for the programming control block.
   Assumes the core model drives the bus and a 20-cycle hold count. */
`timescale 1ns/100ps
`include "epc_params.svh"
module test_eeprom_program_erase_control;
    localparam logic [15:0] CTRL = `EPC_PROG_CTRL_ADDR;
    localparam logic [15:0] OPT = 16'h103f;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic rom_variant = 1'b0;
    logic guard = 1'b0;
    logic security_on = 1'b0;
    logic want_expanded = 1'b0;
    epc_pkg::epc_bus_t bus;
    logic [7:0] rdata;
    logic array_read_en, rom_prog_path, hv_on, hold_done, single_chip_only;
    epc_pkg::epc_nvm_cmd_t nvm_cmd;
    int bad_count = 0;
    int cmp_count = 0;
    // Core clock well above 1 MHz, pump clock choice left to software
    always #20 mclk = ~mclk;
    epc_core_model core (.mclk(mclk), .bus(bus));
    epc_ctrl #(.HOLD_CYCLES(20)) dut (.mclk(mclk), .srst(srst), .ce(1'b1), .bus(bus),
        .rom_variant(rom_variant), .option_write_guard(guard), .security_on(security_on),
        .want_expanded(want_expanded), .rdata(rdata), .array_read_en(array_read_en),
        .rom_prog_path(rom_prog_path), .hv_on(hv_on), .hold_done(hold_done),
        .single_chip_only(single_chip_only), .nvm_cmd(nvm_cmd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic stop_test;
        $display("compares %0d errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] d);
        core.acc(1'b1, CTRL, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] exp, input string m);
        core.acc(1'b0, CTRL, 8'h00);
        chk(rdata, exp, m);
    endtask : rd_chk
    task automatic t_program;
        int n;
        chk(array_read_en, 1'b1, "read path after reset");
        rd_chk(8'h00, "ctrl after reset");
        wr(8'h1a);
        chk(array_read_en, 1'b0, "reads not blocked");
        core.acc(1'b1, 16'hb605, 8'h5a);
        wr(8'h1b);
        chk(hv_on, 1'b1, "voltage off");
        chk({nvm_cmd.hv_on, nvm_cmd.erase, nvm_cmd.bulk, nvm_cmd.row, nvm_cmd.byte_sel},
            5'b10000, "program kind");
        chk({nvm_cmd.addr, nvm_cmd.data}, {16'hb605, 8'h5a}, "program target");
        for (n = 0; n < 60; n++) begin
            @(posedge mclk);
            #1;
            if (hold_done === 1'b1) break;
        end
        if (n == 60) begin
            bad_count++;
            $display("[ERR] %0t hold never ended", $time);
            stop_test();
        end
        chk(n >= 15 && n <= 22, 1'b1, "hold length");
        wr(8'h00);
        chk({hv_on, array_read_en}, 2'b01, "zero write");
    endtask : t_program
    task automatic t_erase;
        logic [7:0] md [4] = '{8'h06, 8'h0e, 8'h16, 8'h1e};
        logic [2:0] ex [4] = '{3'b100, 3'b010, 3'b001, 3'b001};
        for (int i = 0; i < 4; i++) begin
            core.seq(md[i], 16'hb635, 8'h3c);
            chk({nvm_cmd.hv_on, nvm_cmd.erase, nvm_cmd.bulk, nvm_cmd.row, nvm_cmd.byte_sel},
                {2'b11, ex[i]}, "erase kind");
            chk(nvm_cmd.data, 8'hff, "erase data");
            if (i > 0) chk(nvm_cmd.addr, (i == 1) ? 16'hb630 : 16'hb635, "erase addr");
            wr(8'h00);
        end
    endtask : t_erase
    task automatic t_refuse;
        wr(8'h03);
        rd_chk(8'h00, "latch and voltage together");
        wr(8'h01);
        rd_chk(8'h00, "voltage without latch");
        wr(8'h02);
        wr(8'h03);
        rd_chk(8'h03, "voltage after latch");
        wr(8'h00);
    endtask : t_refuse
    task automatic t_rom;
        rom_variant = 1'b1;
        wr(8'h20);
        chk(rom_prog_path, 1'b1, "rom path");
        wr(8'h21);
        chk(hv_on, 1'b1, "rom voltage");
        wr(8'h00);
        chk(rom_prog_path, 1'b0, "rom read path");
        wr(8'h22);
        core.acc(1'b0, CTRL, 8'h00);
        chk(rdata[5] & rdata[1], 1'b0, "both latches");
        wr(8'h00);
        rom_variant = 1'b0;
    endtask : t_rom
    task automatic t_option;
        core.seq(8'h06, OPT, 8'h00);
        chk(nvm_cmd.bulk, 1'b0, "bulk hit option cell");
        wr(8'h00);
        core.seq(8'h16, OPT, 8'h00);
        chk({nvm_cmd.hv_on, nvm_cmd.byte_sel, nvm_cmd.addr}, {2'b11, OPT}, "option erase");
        wr(8'h00);
        core.seq(8'h02, OPT, 8'h0c);
        chk({nvm_cmd.hv_on, nvm_cmd.erase, nvm_cmd.addr, nvm_cmd.data}, {2'b10, OPT, 8'h0c},
            "option program");
        repeat (21) @(posedge mclk);
        #1;
        chk(hold_done, 1'b1, "option hold");
        wr(8'h00);
        // Reset only once the change has completed
        srst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        srst = 1'b0;
        chk({nvm_cmd, hv_on, array_read_en}, {29'h0000000, 2'b01}, "state after reset");
        rd_chk(8'h00, "ctrl after mid reset");
        guard = 1'b1;
        core.seq(8'h02, OPT, 8'h0f);
        chk(nvm_cmd.hv_on & (nvm_cmd.addr === OPT), 1'b0, "guarded option");
        wr(8'h00);
        guard = 1'b0;
    endtask : t_option
    task automatic t_secure;
        want_expanded = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk(single_chip_only, 1'b0, "expanded refused");
        security_on = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk(single_chip_only, 1'b1, "secure expanded");
    endtask : t_secure
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        srst = 1'b0;
        t_program();
        t_erase();
        t_refuse();
        t_rom();
        t_option();
        t_secure();
        stop_test();
    end
endmodule : test_eeprom_program_erase_control
